/* File: hdl/tbc_pkg.sv */
package tbc_pkg;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int SPROCKET_GAP_US = 1500;
    localparam int STOP_DELAY_MS = 16;
    localparam int FWD_RESUME_MS = 55;
    localparam int BWD_RESUME_MS = 36;
    localparam int SPROCKET_GAP_CYC = SPROCKET_GAP_US * (CLK_HZ / 1_000_000);
    localparam int STOP_DELAY_CYC = STOP_DELAY_MS * (CLK_HZ / 1000);
    localparam int FWD_RESUME_CYC = FWD_RESUME_MS * (CLK_HZ / 1000);
    localparam int BWD_RESUME_CYC = BWD_RESUME_MS * (CLK_HZ / 1000);

    // ***************************************************************
    // group counter
    // ***************************************************************
    localparam logic [2:0] GROUP_PRESET = 3'h6;
    localparam logic [2:0] GROUP_CLEAR = 3'h0;
    localparam logic [2:0] GROUP_FIRST = 3'h1;
    localparam logic [2:0] GROUP_LAST = 3'h6;

    // ***************************************************************
    // word positions within a group or a foreign block
    // ***************************************************************
    localparam logic [5:0] WORD_FIRST_END = 6'h00;
    localparam logic [5:0] NATIVE_WINDOW_END = 6'h08;
    localparam logic [5:0] FOREIGN_WINDOW_END = 6'h3a;

    // ***************************************************************
    // carriers
    // ***************************************************************
    typedef struct packed {
        logic fwd_near;
        logic fwd_far;
        logic bwd;
    } tbc_photo_s;

    typedef struct packed {
        logic stop;
        logic resume;
        logic inhibit_read;
    } tbc_read_ctl_s;

endpackage

/* File: hdl/tbc_retrig_timer.sv */
`timescale 1ns/1ps
// retriggerable delay: reload on trigger, one-cycle pulse on reaching zero
module tbc_retrig_timer #(
    parameter int WIDTH = 24
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic trigger,
    input wire logic [WIDTH-1:0] load_value,
    output logic running,
    output logic expired
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic next_expired;

    always_comb begin
        next_count = count;
        next_expired = 1'b0;
        if (trigger) begin
            next_count = load_value;
        end else if (count == WIDTH'(1)) begin
            next_count = '0;
            next_expired = 1'b1;
        end else if (count != '0) begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= '0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            expired <= next_expired;
        end
    end

    assign running = (count != '0);
endmodule

/* File: hdl/tbc_blockette_badspot.sv */
`timescale 1ns/1ps
// Function
// [RULE1] counter steps only in foreign mode
// [RULE2] counts six groups; flag differs in sixth
// [RULE3] gap recognised only once final group begun; last_sprocket_signal is not gated by gap_enable
// [RULE4] foreign mode: window spans whole block
// [RULE5] three flops, step gated, flag at six
// [RULE6] tape select presets counter to six
// [RULE7] native read keeps counter at six
// [RULE8] foreign start read clears, steps per group
// [RULE9] next block wraps six to one
// [RULE10] window sets after first word, closes on strobe
// [RULE11] end-of-window after word nine or 59
// [RULE12] 1.5 ms without sprocket flags last sprocket
// [RULE13] last sprocket suppressed in hash period
// [RULE14] last sprocket in window sets flop
// [RULE15] forward alert retriggers 16 and 55 ms
// [RULE16] 16 ms expiry forward stops reading
// [RULE17] 55 ms expiry resumes reading
// [RULE18] backward alert stops at once, starts 36 ms
// [RULE19] backward holes retrigger 36 ms, then resume
// [RULE20] alert from forward pair or backward cell
// [RULE21] hash period equals gating flop set
// [RULE22] timers are reloading down-counters
module tbc_blockette_badspot #(
    parameter int GAP_CYC = tbc_pkg::SPROCKET_GAP_CYC,
    parameter int STOP_CYC = tbc_pkg::STOP_DELAY_CYC,
    parameter int FWD_CYC = tbc_pkg::FWD_RESUME_CYC,
    parameter int BWD_CYC = tbc_pkg::BWD_RESUME_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic tape_select,
    input wire logic start_read,
    input wire logic foreign_read,
    input wire logic foreign_mode,
    input wire logic read_forward,
    input wire logic read_backward,
    input wire logic sprocket,
    input wire logic group_first_char,
    input wire logic word_end,
    input wire logic [5:0] word_index,
    input wire logic hash_gate,
    input wire logic alert_close_strobe,
    input wire tbc_pkg::tbc_photo_s photo,
    output logic last_blockette_flag,
    output logic gap_enable,
    output logic badspot_window,
    output logic end_of_window,
    output logic last_sprocket_signal,
    output logic last_sprocket_ff,
    output logic badspot_photocell_alert,
    output tbc_pkg::tbc_read_ctl_s read_ctl
);
    // ***************************************************************
    // input synchronisers (pins from the tape unit)
    // ***************************************************************
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] sync_prev;
    logic spr_pulse;
    logic near_s;
    logic far_s;
    logic bwd_s;
    logic alert_prev;
    logic alert_pulse;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            sync_prev <= 4'h0;
            alert_prev <= 1'b0;
        end else begin
            sync_a <= {sprocket, photo.fwd_near, photo.fwd_far, photo.bwd};
            sync_b <= sync_a;
            sync_prev <= sync_b;
            alert_prev <= badspot_photocell_alert;
        end
    end

    assign spr_pulse = sync_b[3] & ~sync_prev[3];
    assign near_s = sync_b[2];
    assign far_s = sync_b[1];
    assign bwd_s = sync_b[0];

    // only one direction is active at a time
    always_comb begin
        if (read_forward) begin
            badspot_photocell_alert = near_s | far_s; // RULE20
        end else if (read_backward) begin
            badspot_photocell_alert = bwd_s; // RULE20
        end else begin
            badspot_photocell_alert = 1'b0;
        end
    end
    // a new hole gives a rising edge of the merged alert only if no selected cell is already lit
    assign alert_pulse = badspot_photocell_alert & ~alert_prev;

    // ***************************************************************
    // group counter
    // ***************************************************************
    logic [2:0] group_count;
    logic [2:0] next_group_count;

    always_comb begin
        next_group_count = group_count;
        if (tape_select) begin
            next_group_count = tbc_pkg::GROUP_PRESET; // RULE6
        end else if (start_read && foreign_read) begin
            next_group_count = tbc_pkg::GROUP_CLEAR; // RULE8
        end else if (foreign_mode && foreign_read && group_first_char) begin // RULE1 RULE7
            if (group_count == tbc_pkg::GROUP_LAST) begin
                next_group_count = tbc_pkg::GROUP_FIRST; // RULE9
            end else begin
                next_group_count = group_count + 3'h1; // RULE5 RULE8
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            group_count <= tbc_pkg::GROUP_PRESET;
        end else begin
            group_count <= next_group_count;
        end
    end

    // high in groups one to five, low in the sixth
    assign last_blockette_flag = (group_count != tbc_pkg::GROUP_LAST); // RULE2 RULE5
    // native tapes keep the count at six, so gaps are always eligible there
    assign gap_enable = ~last_blockette_flag; // RULE3

    // ***************************************************************
    // bad-spot alert window
    // ***************************************************************
    logic next_badspot_window;
    logic next_end_of_window;
    logic [5:0] window_end_word;

    // in foreign mode the group-one test on the count keeps the first word of later groups from reopening it
    always_comb begin
        window_end_word = foreign_mode ? tbc_pkg::FOREIGN_WINDOW_END
                                       : tbc_pkg::NATIVE_WINDOW_END; // RULE4 RULE11
        next_badspot_window = badspot_window;
        next_end_of_window = end_of_window;
        // close first, so a group start in the same cycle reopens the window
        if (alert_close_strobe && end_of_window) begin
            next_badspot_window = 1'b0; // RULE10
        end
        if (word_end && word_index == tbc_pkg::WORD_FIRST_END) begin
            if (!foreign_mode || group_count == tbc_pkg::GROUP_FIRST) begin // RULE4
                next_badspot_window = 1'b1; // RULE10
                next_end_of_window = 1'b0;
            end
        end
        if (word_end && word_index == window_end_word) begin
            next_end_of_window = 1'b1; // RULE11
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            badspot_window <= 1'b0;
            end_of_window <= 1'b0;
        end else begin
            badspot_window <= next_badspot_window;
            end_of_window <= next_end_of_window;
        end
    end

    // ***************************************************************
    // sprocket gap detection
    // ***************************************************************
    logic gap_expired;
    logic next_last_sprocket_signal;
    logic next_last_sprocket_ff;

    tbc_retrig_timer #(.WIDTH(32)) u_gap_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .trigger(spr_pulse), // RULE12 RULE22
        .load_value(32'(GAP_CYC)),
        .running(),
        .expired(gap_expired)
    );

    always_comb begin
        next_last_sprocket_signal = gap_expired & ~hash_gate; // RULE12 RULE13 RULE21
        next_last_sprocket_ff = last_sprocket_ff;
        if (start_read) begin
            next_last_sprocket_ff = 1'b0;
        end
        if (next_last_sprocket_signal && badspot_window) begin
            next_last_sprocket_ff = 1'b1; // RULE14
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_sprocket_signal <= 1'b0;
            last_sprocket_ff <= 1'b0;
        end else begin
            last_sprocket_signal <= next_last_sprocket_signal;
            last_sprocket_ff <= next_last_sprocket_ff;
        end
    end

    // ***************************************************************
    // stop and resume timers
    // ***************************************************************
    logic stop_expired;
    logic fwd_expired;
    logic bwd_expired;
    logic fwd_alert;
    logic bwd_alert;

    assign fwd_alert = alert_pulse & read_forward;
    assign bwd_alert = alert_pulse & read_backward;

    tbc_retrig_timer #(.WIDTH(32)) u_stop_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .trigger(fwd_alert | bwd_alert), // RULE15 RULE18
        .load_value(32'(STOP_CYC)),
        .running(),
        .expired(stop_expired)
    );

    tbc_retrig_timer #(.WIDTH(32)) u_fwd_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .trigger(fwd_alert), // RULE15
        .load_value(32'(FWD_CYC)),
        .running(),
        .expired(fwd_expired)
    );

    tbc_retrig_timer #(.WIDTH(32)) u_bwd_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .trigger(bwd_alert), // RULE19
        .load_value(32'(BWD_CYC)),
        .running(),
        .expired(bwd_expired)
    );

    // ***************************************************************
    // read bad-spot flop and inhibit
    // ***************************************************************
    logic read_badspot;
    logic next_read_badspot;
    tbc_pkg::tbc_read_ctl_s next_read_ctl;

    // reading only stops once a bad spot was seen by the sprocket gap
    always_comb begin
        next_read_badspot = read_badspot;
        next_read_ctl = '{stop: 1'b0, resume: 1'b0, inhibit_read: read_ctl.inhibit_read};
        if (read_badspot && ((read_forward && fwd_expired) || (read_backward && bwd_expired))) begin
            next_read_badspot = 1'b0; // RULE17 RULE19
            next_read_ctl.resume = 1'b1;
            next_read_ctl.inhibit_read = 1'b0;
        end else if (!read_badspot && last_sprocket_ff &&
                     ((read_forward && stop_expired) || bwd_alert)) begin
            next_read_badspot = 1'b1; // RULE14 RULE16 RULE18
            next_read_ctl.stop = 1'b1;
            next_read_ctl.inhibit_read = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            read_badspot <= 1'b0;
            read_ctl <= '0;
        end else begin
            read_badspot <= next_read_badspot;
            read_ctl <= next_read_ctl;
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    chk_flag_on_clear: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
        (start_read && foreign_read && !tape_select) |=> last_blockette_flag)
        else $error("flag not high after foreign start read");
    chk_preset_six: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
        tape_select |=> group_count == 3'h6)
        else $error("tape select did not preset six");
    chk_hold_native: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
        (!foreign_mode && !tape_select && !start_read) |=> $stable(group_count))
        else $error("counter moved outside foreign mode");
    chk_wrap_one: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
        (group_count == 3'h6 && foreign_mode && foreign_read && group_first_char
         && !tape_select && !start_read) |=> group_count == 3'h1)
        else $error("counter did not wrap to one");
    chk_hash_quiet: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
        $past(hash_gate) |-> !last_sprocket_signal)
        else $error("last sprocket inside hash period");
    chk_window_close: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
        (badspot_window && !end_of_window && !word_end) |=> badspot_window)
        else $error("window closed early");
    chk_stop_inhibit: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
        read_ctl.stop |-> read_ctl.inhibit_read ##1 read_badspot)
        else $error("stop without inhibit");
    chk_resume_clear: assert property (@(posedge clk_sys) disable iff (rst) // RULE17
        read_ctl.resume |-> !read_ctl.inhibit_read && !read_badspot)
        else $error("resume left inhibit set");
    chk_bwd_immediate: assert property (@(posedge clk_sys) disable iff (rst) // RULE18
        (bwd_alert && last_sprocket_ff && !read_badspot) |=> read_badspot)
        else $error("backward alert did not stop at once");
endmodule

/* File: tb/tbc_tape_model.sv */
`timescale 1ns/1ps
// ***************************************************************
// tape unit: sprocket train and bad-spot photocells
// ***************************************************************
module tbc_tape_model #(
    parameter int HOLE_CYC = 8
) (
    input wire logic clk_sys,
    input wire logic sprocket_run,
    input wire logic [2:0] punch,
    output logic sprocket,
    output tbc_pkg::tbc_photo_s photo
);
    int cnt [3] = '{0, 0, 0};
    int ph = 0;

    // sprocket line stands low between frames, never free running
    always @(posedge clk_sys) begin
        ph <= (ph + 1) % 3;
        sprocket <= sprocket_run && (ph == 0);
        for (int i = 0; i < 3; i++) begin
            if (punch[i]) begin
                cnt[i] <= HOLE_CYC;
            end else if (cnt[i] > 0) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
    end

    // hole passes the cell for a few cycles, dark otherwise
    assign photo = {cnt[2] > 0, cnt[1] > 0, cnt[0] > 0};
endmodule

/* File: tb/tbc_blockette_badspot_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tbc_blockette_badspot_bench;
    localparam int GAP = 20;
    localparam int STP = 50;
    localparam int FWD = 120;
    localparam int BWD = 80;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic tape_select = 1'b0, start_read = 1'b0, foreign_read = 1'b0, foreign_mode = 1'b0;
    logic read_forward = 1'b0, read_backward = 1'b0, sprocket, group_first_char = 1'b0;
    logic word_end = 1'b0, hash_gate = 1'b0, alert_close_strobe = 1'b0, sprocket_run = 1'b0;
    logic [5:0] word_index = 6'h00;
    logic [2:0] punch = 3'h0;
    logic last_blockette_flag, gap_enable, badspot_window, end_of_window;
    logic last_sprocket_signal, last_sprocket_ff, badspot_photocell_alert;
    tbc_pkg::tbc_photo_s photo;
    tbc_pkg::tbc_read_ctl_s read_ctl;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    int m;
    // {tape_select, start_read, foreign_read, foreign_mode, first_char, flag}
    logic [5:0] rows [18] = '{6'h20, 6'h1d, 6'h0f, 6'h0f, 6'h0f, 6'h0f, 6'h0f, 6'h0e, 6'h0f,
        6'h0f, 6'h0f, 6'h0f, 6'h0f, 6'h0b, 6'h0e, 6'h20, 6'h10, 6'h06};

    tbc_blockette_badspot #(.GAP_CYC(GAP), .STOP_CYC(STP), .FWD_CYC(FWD), .BWD_CYC(BWD)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .tape_select(tape_select), .start_read(start_read),
        .foreign_read(foreign_read), .foreign_mode(foreign_mode), .read_forward(read_forward),
        .read_backward(read_backward), .sprocket(sprocket), .group_first_char(group_first_char),
        .word_end(word_end), .word_index(word_index), .hash_gate(hash_gate),
        .alert_close_strobe(alert_close_strobe), .photo(photo),
        .last_blockette_flag(last_blockette_flag), .gap_enable(gap_enable),
        .badspot_window(badspot_window), .end_of_window(end_of_window),
        .last_sprocket_signal(last_sprocket_signal), .last_sprocket_ff(last_sprocket_ff),
        .badspot_photocell_alert(badspot_photocell_alert), .read_ctl(read_ctl));

    tbc_tape_model u_tape (.clk_sys(clk_sys), .sprocket_run(sprocket_run), .punch(punch),
        .sprocket(sprocket), .photo(photo));

    initial forever #10 clk_sys = ~clk_sys;

    // ***************************************************************
    // drivers
    // ***************************************************************
    task pulse(input logic [4:0] p, input logic [5:0] idx);
        @(posedge clk_sys);
        {tape_select, start_read, group_first_char, word_end, alert_close_strobe} <= p;
        word_index <= idx;
        @(posedge clk_sys);
        {tape_select, start_read, group_first_char, word_end, alert_close_strobe} <= 5'h00;
        @(negedge clk_sys);
    endtask

    task hole(input logic [2:0] p);
        @(posedge clk_sys);
        punch <= p;
        @(posedge clk_sys);
        punch <= 3'h0;
    endtask

    // pulses stand one cycle, so look right after every edge
    task wait_sig(input int w, input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim) begin
            @(posedge clk_sys);
            #1;
            if ((w == 0 && read_ctl.stop === 1'b1) || (w == 1 && read_ctl.resume === 1'b1) ||
                (w == 2 && last_sprocket_signal === 1'b1)) break;
            cnt++;
        end
    endtask

    task do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
    endtask

    task close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the whole run is near 500 cycles; the ceiling leaves ample room
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    // ***************************************************************
    // scenarios
    // ***************************************************************
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        `CHK("flag after reset", 1'b0, last_blockette_flag)
        `CHK("read ctl after reset", 3'h0, read_ctl)
        for (int i = 0; i < 18; i++) begin
            @(posedge clk_sys);
            foreign_read <= rows[i][3];
            foreign_mode <= rows[i][2];
            pulse({rows[i][5], rows[i][4], rows[i][1], 2'b00}, 6'h00);
            `CHK("blockette flag", rows[i][0], last_blockette_flag)
            `CHK("gap enable", ~rows[i][0], gap_enable)
        end
        do_reset();
        foreign_mode <= 1'b1;
        pulse(5'h02, 6'h08);
        `CHK("foreign end at nine", 1'b0, end_of_window)
        pulse(5'h02, 6'h3a);
        `CHK("foreign end at 59", 1'b1, end_of_window)
        do_reset();
        foreign_mode <= 1'b0;
        pulse(5'h02, 6'h00);
        `CHK("window open", 1'b1, badspot_window)
        pulse(5'h01, 6'h00);
        `CHK("early close ignored", 1'b1, badspot_window)
        pulse(5'h02, 6'h08);
        `CHK("native end at nine", 1'b1, end_of_window)
        pulse(5'h01, 6'h00);
        `CHK("window closed", 1'b0, badspot_window)
        pulse(5'h02, 6'h00);
        sprocket_run <= 1'b1;
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("no gap while running", 1'b0, last_sprocket_signal)
        sprocket_run <= 1'b0;
        wait_sig(2, GAP + 20, n);
        `CHK("gap delay", 1'b1, n >= GAP && n <= GAP + 10)
        `CHK("last sprocket flop", 1'b1, last_sprocket_ff)
        hash_gate <= 1'b1;
        sprocket_run <= 1'b1;
        repeat (30) @(posedge clk_sys);
        sprocket_run <= 1'b0;
        wait_sig(2, GAP + 20, n);
        `CHK("hash suppress", GAP + 20, n)
        hash_gate <= 1'b0;
        read_forward <= 1'b1;
        hole(3'b010);
        repeat (3) @(negedge clk_sys);
        `CHK("forward alert", 1'b1, badspot_photocell_alert)
        // let the far cell go dark so the near cell gives a fresh alert edge
        repeat (10) @(posedge clk_sys);
        hole(3'b100);
        wait_sig(0, STP + 20, n);
        `CHK("stop after retrigger", 1'b1, n >= STP && n <= STP + 10)
        `CHK("inhibit set", 1'b1, read_ctl.inhibit_read)
        wait_sig(1, FWD, m);
        `CHK("forward resume", 1'b1, n + m >= FWD && n + m <= FWD + 10)
        `CHK("inhibit clear", 1'b0, read_ctl.inhibit_read)
        read_forward <= 1'b0;
        read_backward <= 1'b1;
        hole(3'b100);
        repeat (3) @(negedge clk_sys);
        `CHK("forward cell ignored", 1'b0, badspot_photocell_alert)
        repeat (10) @(posedge clk_sys);
        hole(3'b001);
        wait_sig(0, 12, n);
        `CHK("backward stop", 1'b1, n < 12)
        repeat (30) @(posedge clk_sys);
        hole(3'b001);
        wait_sig(1, BWD + 20, n);
        `CHK("backward resume", 1'b1, n >= BWD && n <= BWD + 10)
        pulse(5'h08, 6'h00);
        `CHK("start read clears flop", 1'b0, last_sprocket_ff)
        hole(3'b001);
        wait_sig(0, 12, n);
        `CHK("no stop without flop", 12, n)
        close_out();
    end
endmodule
